/* include/pin_routing_pkg.sv */
// Register map, field layout, source codes and carriers for serial-port pin routing.
package pin_routing_pkg;

   // ----------------------------------------------------------------
   // Register offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] SECONDARY_PORT_CLOCK_SELECT = 8'h11;
   localparam logic [7:0] SECONDARY_PORT_DATA_SELECT = 8'h12;
   localparam logic [7:0] DIGITAL_MIC_ROUTING = 8'h13;
   localparam logic [7:0] PIN_POWER_CONTROL_SELECT = 8'h14;
   localparam logic [7:0] PIN_BIAS_CONVERT_SELECT = 8'h15;
   localparam logic [7:0] SERIAL_PORT_ENABLE_DAISY = 8'h18;
   localparam logic [7:0] SERIAL_PORT_LANE_CONFIG = 8'h19;

   localparam logic [7:0] CLOCK_SELECT_RESET = 8'h80;
   localparam logic [7:0] DATA_SELECT_RESET = 8'h00;
   localparam logic [7:0] MIC_ROUTING_RESET = 8'h00;
   localparam logic [7:0] POWER_SELECT_RESET = 8'h00;
   localparam logic [7:0] BIAS_SELECT_RESET = 8'h00;
   localparam logic [7:0] ENABLE_DAISY_RESET = 8'h40;
   localparam logic [7:0] LANE_CONFIG_RESET = 8'h00;

   // Writable bits; reserved bits hold zero and read as zero.
   localparam logic [7:0] CLOCK_SELECT_MASK = 8'hFE;
   localparam logic [7:0] DATA_SELECT_MASK = 8'hFC;
   localparam logic [7:0] BIAS_SELECT_MASK = 8'hF0;
   localparam logic [7:0] LANE_CONFIG_MASK = 8'hF8;
   localparam logic [7:0] FULL_MASK = 8'hFF;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PRIMARY_INPUT_ENABLE_BIT = 7;
   localparam int FSYNC_SRC_LSB = 4;
   localparam int BCLK_SRC_LSB = 1;
   localparam int DIN1_SRC_LSB = 5;
   localparam int DIN2_SRC_LSB = 2;
   localparam int CH1_TYPE_BIT = 7;
   localparam int CH2_TYPE_BIT = 6;
   localparam int PAIR_A_EDGE_BIT = 5;
   localparam int PAIR_B_EDGE_BIT = 4;
   localparam int PAIR_A_PIN_LSB = 2;
   localparam int PAIR_B_PIN_LSB = 0;
   localparam int MIC_OVERRIDE_BIT = 7;
   localparam int DOUT_WITH_DIN_BIT = 6;
   localparam int ADC_PD_PIN_LSB = 4;
   localparam int DAC_PD_PIN_LSB = 2;
   localparam int LIMITER_BIT = 1;
   localparam int ANALOG_FN_BIT = 0;
   localparam int MBIAS_PIN_LSB = 6;
   localparam int CONVST_PIN_LSB = 4;
   localparam int PRIMARY_DISABLE_BIT = 7;
   localparam int SECONDARY_DISABLE_BIT = 6;
   localparam int GANG_BIT = 5;
   localparam int DAISY_MODE_LSB = 3;
   localparam int DAISY_IN_LSB = 0;
   localparam int OUT_LANES_LSB = 6;
   localparam int IN_LANES_LSB = 4;
   localparam int DAISY_DIR_BIT = 3;

   localparam int DAISY_BUFFER_DEPTH = 64;

   // ----------------------------------------------------------------
   // Source codes
   // ----------------------------------------------------------------
   localparam logic [2:0] SRC_OFF = 3'h0;
   localparam logic [2:0] SRC_GENERAL_IO = 3'h1;
   localparam logic [2:0] SRC_AUX_B = 3'h2;
   localparam logic [2:0] SRC_AUX_A = 3'h3;
   localparam logic [2:0] SRC_DATA_OUT_PIN = 3'h4;
   localparam logic [2:0] SRC_PRIMARY = 3'h5;

   localparam logic [1:0] DAISY_OFF = 2'h0;
   localparam logic [1:0] DAISY_PRIMARY = 2'h1;
   localparam logic [1:0] DAISY_SECONDARY = 2'h2;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic general_io_pin;
      logic aux_input_pin_b;
      logic aux_input_pin_a;
      logic primary_frame_sync;
      logic primary_bit_clock;
      logic primary_data;
      logic data_out_pin;
      logic pdm_clock;
   } pin_bundle_t;

   typedef struct packed {
      logic frame_sync;
      logic bit_clock;
      logic data_in1;
      logic data_in2;
   } secondary_route_t;

   typedef struct packed {
      logic adc_powerdown;
      logic dac_powerdown;
      logic mic_bias_enable;
      logic aux_converter_start;
      logic limiter_function;
      logic general_analog_function;
   } pin_control_t;

   typedef struct packed {
      logic primary_active;
      logic secondary_active;
      logic secondary_follows_primary;
      logic [1:0] daisy_mode;
      logic daisy_data;
      logic daisy_on_input;
      logic [1:0] output_lane_config;
      logic [1:0] input_lane_config;
   } port_config_t;

endpackage

/* src/serial_port_pin_routing.sv */
// Register file and pin routing for the stereo codec's audio serial ports.
//
// Contract
// - Bit 7 of 0x11 enables primary data input; resets enabled.
// - Bits 6-4 pick secondary frame sync source; 4, 6, 7 reserved.
// - Bits 3-1 pick secondary bit clock source, same codes.
// - Bits 7-5 of 0x12 pick secondary first data input source.
// - Bits 4-2 pick secondary second data input, same codes.
// - Bits 7, 6 choose analog or PDM source for record channels 1, 2.
// - Bit 5 chooses latching edges for PDM channels 1 and 2.
// - Bit 4 chooses latching edges for PDM channels 3 and 4.
// - Two-bit fields pick the PDM data pin for each channel pair.
// - Override makes an aux A PDM selection use the data input pin.
// - Bit 6 lets the data-output pin also serve as data input.
// - Selected pin or register bit powers down the ADC.
// - Selected pin or register bit powers down the DAC.
// - Bits 1, 0 give limiter and analog functions to general I/O.
// - Bits 7-6 of 0x15 pick the mic bias enable pin.
// - Bits 5-4 pick the pin starting an aux converter conversion.
// - Bits 7, 6 of 0x18 disable the ports; secondary off at reset.
// - Ganging bit makes secondary port use primary configuration.
// - Daisy field selects off, primary or secondary chain; 3 reserved.
// - Bits 2-0 pick the daisy chain input; 4, 6, 7 reserved.
// - Bits 7-6 of 0x19 set data output lanes; 3 reserved.
// - Bits 5-4 set data input lanes; bit 3 sets daisy direction.
`timescale 1ns/1ps

module serial_port_pin_routing
   import pin_routing_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire pin_bundle_t pins,
   input wire logic adc_power_register_bit,
   input wire logic dac_power_register_bit,
   output logic primary_data_routed,
   output logic data_out_bidir,
   output secondary_route_t secondary_route,
   output logic [1:0] record_source_type,
   output logic [3:0] mic_channel_data,
   output pin_control_t pin_control,
   output port_config_t port_config
);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [7:0] clock_select;
   logic [7:0] data_select;
   logic [7:0] mic_routing;
   logic [7:0] power_select;
   logic [7:0] bias_select;
   logic [7:0] enable_daisy;
   logic [7:0] lane_config;

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         clock_select <= CLOCK_SELECT_RESET;
         data_select <= DATA_SELECT_RESET;
         mic_routing <= MIC_ROUTING_RESET;
         power_select <= POWER_SELECT_RESET;
         bias_select <= BIAS_SELECT_RESET;
         enable_daisy <= ENABLE_DAISY_RESET;
         lane_config <= LANE_CONFIG_RESET;
      end
      else if (clk_en && reg_wr)
      begin
         case (reg_addr)
            SECONDARY_PORT_CLOCK_SELECT: clock_select <= reg_wdata & CLOCK_SELECT_MASK;
            SECONDARY_PORT_DATA_SELECT: data_select <= reg_wdata & DATA_SELECT_MASK;
            DIGITAL_MIC_ROUTING: mic_routing <= reg_wdata & FULL_MASK;
            PIN_POWER_CONTROL_SELECT: power_select <= reg_wdata & FULL_MASK;
            PIN_BIAS_CONVERT_SELECT: bias_select <= reg_wdata & BIAS_SELECT_MASK;
            SERIAL_PORT_ENABLE_DAISY: enable_daisy <= reg_wdata & FULL_MASK;
            SERIAL_PORT_LANE_CONFIG: lane_config <= reg_wdata & LANE_CONFIG_MASK;
            default:
            begin
            end
         endcase
      end
   end

   // Unmapped offsets read as zero.
   always_ff @(posedge mclk)
   begin
      if (srst)
         reg_rdata <= 8'h00;
      else if (clk_en && reg_rd)
      begin
         case (reg_addr)
            SECONDARY_PORT_CLOCK_SELECT: reg_rdata <= clock_select;
            SECONDARY_PORT_DATA_SELECT: reg_rdata <= data_select;
            DIGITAL_MIC_ROUTING: reg_rdata <= mic_routing;
            PIN_POWER_CONTROL_SELECT: reg_rdata <= power_select;
            PIN_BIAS_CONVERT_SELECT: reg_rdata <= bias_select;
            SERIAL_PORT_ENABLE_DAISY: reg_rdata <= enable_daisy;
            SERIAL_PORT_LANE_CONFIG: reg_rdata <= lane_config;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int PIN_COUNT = $bits(pin_bundle_t);
   logic [PIN_COUNT-1:0] pin_meta;
   logic [PIN_COUNT-1:0] pin_sync_bits;
   pin_bundle_t pin_sync;

   generate
      for (genvar i = 0; i < PIN_COUNT; i++)
      begin : g_sync
         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               pin_meta[i] <= 1'b0;
               pin_sync_bits[i] <= 1'b0;
            end
            else if (clk_en)
            begin
               pin_meta[i] <= pins[i];
               pin_sync_bits[i] <= pin_meta[i];
            end
         end
      end
   endgenerate

   assign pin_sync = pin_bundle_t'(pin_sync_bits);

   // ----------------------------------------------------------------
   // Source selection
   // ----------------------------------------------------------------
   // Codes 6 and 7 fall to the default and route nothing; where code 4 is reserved the caller passes zero for code4.
   function automatic logic pick_source(input logic [2:0] code, input pin_bundle_t p,
                                        input logic code4, input logic code5);
      case (code)
         SRC_GENERAL_IO: pick_source = p.general_io_pin;
         SRC_AUX_B: pick_source = p.aux_input_pin_b;
         SRC_AUX_A: pick_source = p.aux_input_pin_a;
         SRC_DATA_OUT_PIN: pick_source = code4;
         SRC_PRIMARY: pick_source = code5;
         default: pick_source = 1'b0;
      endcase
   endfunction

   logic primary_input_enable;
   logic [2:0] secondary_frame_sync_source;
   logic [2:0] secondary_bit_clock_source;
   logic [2:0] secondary_input_source;
   logic [2:0] secondary_second_input_source;
   logic [1:0] mic_pair_a_pin;
   logic [1:0] mic_pair_b_pin;
   logic mic_pin_override;
   logic [1:0] adc_powerdown_pin;
   logic [1:0] dac_powerdown_pin;
   logic [1:0] mic_bias_enable_pin;
   logic [1:0] aux_converter_start_pin;
   logic [1:0] daisy_mode;
   logic [2:0] daisy_input_source;
   logic primary_data_source;

   assign primary_input_enable = clock_select[PRIMARY_INPUT_ENABLE_BIT];
   assign secondary_frame_sync_source = clock_select[FSYNC_SRC_LSB +: 3];
   assign secondary_bit_clock_source = clock_select[BCLK_SRC_LSB +: 3];
   assign secondary_input_source = data_select[DIN1_SRC_LSB +: 3];
   assign secondary_second_input_source = data_select[DIN2_SRC_LSB +: 3];
   assign mic_pair_a_pin = mic_routing[PAIR_A_PIN_LSB +: 2];
   assign mic_pair_b_pin = mic_routing[PAIR_B_PIN_LSB +: 2];
   assign mic_pin_override = power_select[MIC_OVERRIDE_BIT];
   assign adc_powerdown_pin = power_select[ADC_PD_PIN_LSB +: 2];
   assign dac_powerdown_pin = power_select[DAC_PD_PIN_LSB +: 2];
   assign mic_bias_enable_pin = bias_select[MBIAS_PIN_LSB +: 2];
   assign aux_converter_start_pin = bias_select[CONVST_PIN_LSB +: 2];
   assign daisy_mode = enable_daisy[DAISY_MODE_LSB +: 2];
   assign daisy_input_source = enable_daisy[DAISY_IN_LSB +: 3];

   // shared data pin
   // With the shared mode on, the data-output pin carries the serial input too.
   assign primary_data_source = power_select[DOUT_WITH_DIN_BIT] ? pins_dout_or_data() :
                                pin_sync.primary_data;

   function automatic logic pins_dout_or_data();
      pins_dout_or_data = pin_sync.data_out_pin;
   endfunction

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         primary_data_routed <= 1'b0;
         data_out_bidir <= 1'b0;
      end
      else if (clk_en)
      begin
         primary_data_routed <= primary_input_enable & primary_data_source;
         data_out_bidir <= power_select[DOUT_WITH_DIN_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Secondary port routing
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (srst)
         secondary_route <= '0;
      else if (clk_en)
      begin
         secondary_route.frame_sync <= pick_source(secondary_frame_sync_source, pin_sync,
                                                   1'b0, pin_sync.primary_frame_sync);
         secondary_route.bit_clock <= pick_source(secondary_bit_clock_source, pin_sync,
                                                  1'b0, pin_sync.primary_bit_clock);
         secondary_route.data_in1 <= pick_source(secondary_input_source, pin_sync,
                                                 pin_sync.data_out_pin, primary_data_source);
         secondary_route.data_in2 <= pick_source(secondary_second_input_source, pin_sync,
                                                 pin_sync.data_out_pin, primary_data_source);
      end
   end

   // ----------------------------------------------------------------
   // PDM microphone capture
   // ----------------------------------------------------------------
   logic pdm_clock_prev;
   logic pdm_rise;
   logic pdm_fall;
   logic pair_a_data;
   logic pair_b_data;

   always_ff @(posedge mclk)
   begin
      if (srst)
         pdm_clock_prev <= 1'b0;
      else if (clk_en)
         pdm_clock_prev <= pin_sync.pdm_clock;
   end

   assign pdm_rise = pin_sync.pdm_clock & ~pdm_clock_prev;
   assign pdm_fall = ~pin_sync.pdm_clock & pdm_clock_prev;

   // aux override
   // The override only redirects an aux A choice; other codes are untouched.
   assign pair_a_data = (mic_pin_override && {1'b0, mic_pair_a_pin} == SRC_AUX_A) ?
                        pin_sync.primary_data :
                        pick_source({1'b0, mic_pair_a_pin}, pin_sync, 1'b0, 1'b0);
   assign pair_b_data = (mic_pin_override && {1'b0, mic_pair_b_pin} == SRC_AUX_A) ?
                        pin_sync.primary_data :
                        pick_source({1'b0, mic_pair_b_pin}, pin_sync, 1'b0, 1'b0);

   always_ff @(posedge mclk)
   begin
      if (srst)
         mic_channel_data <= 4'h0;
      else if (clk_en)
      begin
         if (mic_routing[PAIR_A_EDGE_BIT] ? pdm_rise : pdm_fall)
            mic_channel_data[0] <= pair_a_data;
         if (mic_routing[PAIR_A_EDGE_BIT] ? pdm_fall : pdm_rise)
            mic_channel_data[1] <= pair_a_data;
         if (mic_routing[PAIR_B_EDGE_BIT] ? pdm_rise : pdm_fall)
            mic_channel_data[2] <= pair_b_data;
         if (mic_routing[PAIR_B_EDGE_BIT] ? pdm_fall : pdm_rise)
            mic_channel_data[3] <= pair_b_data;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         record_source_type <= 2'h0;
      else if (clk_en)
         record_source_type <= {mic_routing[CH2_TYPE_BIT], mic_routing[CH1_TYPE_BIT]};
   end

   // ----------------------------------------------------------------
   // Pin-driven controls
   // ----------------------------------------------------------------
   logic convert_pin;
   logic convert_pin_prev;

   assign convert_pin = pick_source({1'b0, aux_converter_start_pin}, pin_sync, 1'b0, 1'b0);

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         pin_control <= '0;
         convert_pin_prev <= 1'b0;
      end
      else if (clk_en)
      begin
         // ADC power down
         // The register bit is active-low power down: zero requests it.
         pin_control.adc_powerdown <= ~adc_power_register_bit |
            pick_source({1'b0, adc_powerdown_pin}, pin_sync, 1'b0, 1'b0);
         pin_control.dac_powerdown <= ~dac_power_register_bit |
            pick_source({1'b0, dac_powerdown_pin}, pin_sync, 1'b0, 1'b0);
         pin_control.mic_bias_enable <= pick_source({1'b0, mic_bias_enable_pin}, pin_sync,
                                                    1'b0, 1'b0);
         // conversion start pulse
         // A held pin starts one conversion, so only its rising edge counts.
         convert_pin_prev <= convert_pin;
         pin_control.aux_converter_start <= convert_pin & ~convert_pin_prev;
         pin_control.limiter_function <= power_select[LIMITER_BIT] & pin_sync.general_io_pin;
         pin_control.general_analog_function <= power_select[ANALOG_FN_BIT] &
                                                 pin_sync.general_io_pin;
      end
   end

   // ----------------------------------------------------------------
   // Port enables, daisy chain and lanes
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (srst)
         port_config <= '0;
      else if (clk_en)
      begin
         // daisy mode
         // A daisy chain on one port takes the other one out of service.
         port_config.primary_active <= ~enable_daisy[PRIMARY_DISABLE_BIT] &
                                       (daisy_mode != DAISY_SECONDARY);
         port_config.secondary_active <= ~enable_daisy[SECONDARY_DISABLE_BIT] &
                                         (daisy_mode != DAISY_PRIMARY);
         port_config.daisy_mode <= (daisy_mode == DAISY_PRIMARY ||
                                    daisy_mode == DAISY_SECONDARY) ? daisy_mode : DAISY_OFF;
         port_config.secondary_follows_primary <= enable_daisy[GANG_BIT];
         port_config.daisy_data <= pick_source(daisy_input_source, pin_sync, 1'b0,
                                               pin_sync.primary_data);
         port_config.output_lane_config <= lane_config[OUT_LANES_LSB +: 2];
         port_config.input_lane_config <= lane_config[IN_LANES_LSB +: 2];
         port_config.daisy_on_input <= lane_config[DAISY_DIR_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   sequence write_seq(logic [7:0] addr);
      clk_en && reg_wr && reg_addr == addr;
   endsequence

   sequence read_seq(logic [7:0] addr);
      clk_en && reg_rd && !reg_wr && reg_addr == addr;
   endsequence

   primary_gate_a: assert property (clk_en && !primary_input_enable |=> !primary_data_routed)
      else $error("primary data passed while disabled");
   fsync_off_a: assert property ((clk_en && secondary_frame_sync_source == SRC_OFF)
      |=> !secondary_route.frame_sync)
      else $error("secondary frame sync routed while off");
   bclk_primary_a: assert property ((clk_en && secondary_bit_clock_source == SRC_PRIMARY)
      |=> secondary_route.bit_clock == $past(pin_sync.primary_bit_clock))
      else $error("secondary bit clock does not follow primary");
   din_dout_a: assert property ((clk_en && secondary_input_source == SRC_DATA_OUT_PIN)
      |=> secondary_route.data_in1 == $past(pin_sync.data_out_pin))
      else $error("secondary data input not from data-output pin");
   clock_sel_rb_a: assert property (write_seq(SECONDARY_PORT_CLOCK_SELECT) ##1 read_seq(
      SECONDARY_PORT_CLOCK_SELECT) |=> reg_rdata == ($past(reg_wdata, 2) & CLOCK_SELECT_MASK))
      else $error("clock select readback mismatch");
   ch1_fall_a: assert property ((clk_en && !mic_routing[PAIR_A_EDGE_BIT] && pdm_rise)
      |=> $stable(mic_channel_data[0]))
      else $error("channel 1 latched on rising edge");
   ch3_edge_a: assert property ((clk_en && mic_routing[PAIR_B_EDGE_BIT] && pdm_fall)
      |=> $stable(mic_channel_data[2]))
      else $error("channel 3 latched on falling edge");
   adc_pd_a: assert property ((clk_en && !adc_power_register_bit) |=> pin_control.adc_powerdown)
      else $error("adc not powered down");
   dac_pd_a: assert property ((clk_en && !dac_power_register_bit) |=> pin_control.dac_powerdown)
      else $error("dac not powered down");
   start_pulse_a: assert property (pin_control.aux_converter_start |=>
      !pin_control.aux_converter_start || !$past(clk_en))
      else $error("conversion start longer than one cycle");
   daisy_excl_a: assert property ((clk_en && daisy_mode == DAISY_PRIMARY)
      |=> !port_config.secondary_active)
      else $error("secondary active during primary daisy");
   reset_state_a: assert property (($fell(srst) && clk_en) |=> port_config.primary_active
      && !port_config.secondary_active)
      else $error("port state wrong after reset");

endmodule

/* test/mic_host_model.sv */
// Audio host and PDM microphone levels seen on the routed pins.
`timescale 1ns/1ps
module mic_host_model
   import pin_routing_pkg::*;
(
   input wire logic mclk,
   input wire logic [3:0] level,
   output pin_bundle_t pins
);
   logic [2:0] div = 3'h0;
   // The microphone clock is slow so every edge crosses the two-flop synchroniser.
   always @(posedge mclk) div <= div + 3'h1;
   assign pins = {level[0], level[1], level[2], level[3], ~level[3], level[3], ~level[0], div[2]};
endmodule

/* test/serial_port_pin_routing_bench.sv */
// Self-checking bench for the serial-port pin routing block.
`timescale 1ns/1ps
module serial_port_pin_routing_bench;
   import pin_routing_pkg::*;
   logic mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, adc_b = 1'b1, dac_b = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
   logic [3:0] level = 4'h0, mic;
   logic [1:0] src_type;
   logic pdr, dob;
   pin_bundle_t pins;
   secondary_route_t sr;
   pin_control_t pc;
   port_config_t cfg;
   int num_errors = 0, total_checks = 0;
   logic [7:0] addrs [7] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h18, 8'h19};
   logic [7:0] resets [7] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
   logic [7:0] masks [7] = '{8'hFE, 8'hFC, 8'hFF, 8'hFF, 8'hF0, 8'hFF, 8'hF8};
   initial forever #50 mclk = ~mclk;
   mic_host_model host_u (.mclk(mclk), .level(level), .pins(pins));
   serial_port_pin_routing dut_u (.mclk(mclk), .srst(srst), .clk_en(1'b1), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .pins(pins), .adc_power_register_bit(adc_b), .dac_power_register_bit(dac_b),
      .primary_data_routed(pdr), .data_out_bidir(dob), .secondary_route(sr),
      .record_source_type(src_type), .mic_channel_data(mic), .pin_control(pc), .port_config(cfg));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      total_checks++;
      if (seen !== want)
      begin
         num_errors++;
         $display("FAIL %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      // Two edges from strobe to output plus pin sync margin.
      repeat (4) @(posedge mclk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      #1 v = reg_rdata;
   endtask
   task automatic t_regs;
      for (int i = 0; i < 7; i++)
      begin
         rd(addrs[i]);
         check(v, resets[i]);
         wr(addrs[i], 8'hFF);
         rd(addrs[i]);
         check(v, masks[i]);
      end
      wr(8'h16, 8'hFF);
      rd(8'h16);
      check(v, 8'h00);
   endtask
   task automatic t_route;
      level <= 4'b1101;
      check({7'h0, dob}, 8'h01);
      wr(8'h14, 8'h00);
      check({7'h0, dob}, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         wr(8'h11, {1'b1, c[2:0], c[2:0], 1'b0});
         check({6'h0, sr.frame_sync, sr.bit_clock}, {6'h0, 1'(8'h2A >> c), 1'(8'h0A >> c)});
      end
      check({7'h0, pdr}, 8'h01);
      wr(8'h11, 8'h00);
      check({7'h0, pdr}, 8'h00);
   endtask
   task automatic t_power;
      wr(8'h14, 8'h33);
      wr(8'h13, 8'h80);
      check({2'h0, pc}, 8'h2B);
      check({6'h0, src_type}, 8'h01);
      dac_b <= 1'b0;
      wr(8'h14, 8'h30);
      check({6'h0, pc.adc_powerdown, pc.dac_powerdown}, 8'h03);
   endtask
   task automatic t_ports;
      wr(8'h18, 8'h08);
      check({4'h0, cfg.primary_active, cfg.secondary_active, cfg.daisy_mode}, 8'h09);
      wr(8'h18, 8'h10);
      check({4'h0, cfg.primary_active, cfg.secondary_active, cfg.daisy_mode}, 8'h06);
      wr(8'h18, 8'h98);
      check({4'h0, cfg.primary_active, cfg.secondary_active, cfg.daisy_mode}, 8'h04);
      check({cfg.output_lane_config, cfg.input_lane_config, cfg.daisy_on_input,
         cfg.secondary_follows_primary, 2'h0}, 8'hF8);
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      t_regs;
      t_route;
      t_power;
      t_ports;
      finish_test;
   end
endmodule
